// ---- rtl/cmd_consts.svh ----
// constants of the command interpreter: codes, lengths, limits, defaults
// assumes inclusion by bare name from every rtl file that needs them
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH

// ----------------------------------------
// framing
// ----------------------------------------
`define SOF        8'h02
`define REPLY_BIT  8'h40
`define LEN_NONE   8'h00
`define LEN_ONE    8'h01

// ----------------------------------------
// command codes
// ----------------------------------------
`define Q_VERSION  8'h0C
`define Q_IDENT    8'h0B
`define Q_SRST     8'h05
`define Q_RSSI     8'h0D
`define Q_LOADER   8'h12
`define Q_OPMODE   8'h28
`define Q_CHAN     8'h20
`define Q_ADDR     8'h21
`define Q_SUBNET   8'h22
`define Q_POWER    8'h23
`define IND_STATE  8'hC0

// ----------------------------------------
// answer lengths and values
// ----------------------------------------
`define LEN_VERSION 3'h3
`define LEN_IDENT   3'h4
`define LEN_STATUS  3'h1
`define ST_OK       8'h00
`define ST_ERR      8'h01
`define MODE_LP     8'h01

// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define CHAN_MAX   8'h13
`define ADDR_MAX   8'hFE
`define POWER_MAX  8'h0A
`define DEF_CHAN   8'h06
`define DEF_ADDR   8'h00
`define DEF_SUBNET 8'h01
`define DEF_POWER  8'h05
`define RSSI_NONE  8'h00

// ----------------------------------------
// identity, values arbitrary
// ----------------------------------------
`define VER_MAJOR  8'h01
`define VER_MINOR  8'h00
`define VER_REV    8'h00
`define PRODUCT_ID 8'h5A
`define SERIAL_NO  24'h00_0001

`endif

// ---- rtl/cmd_pkg.sv ----
// types shared by the command interpreter and its frame sender
// assumes nothing beyond a SystemVerilog compiler
package cmd_pkg;

	// ----------------------------------------
	// frame to send
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]      cmd;
		logic [2:0]      len;
		logic [3:0][7:0] pay;
	} txreq_t;

	// ----------------------------------------
	// state machines
	// ----------------------------------------
	typedef enum logic [2:0] {R_IDLE, R_CMD, R_LEN, R_PAY, R_CS} rx_st_t;
	typedef enum logic [1:0] {PH_RUN, PH_SRST, PH_LOAD, PH_BOOT} phase_t;

	typedef struct packed {
		rx_st_t     rs;
		logic [7:0] cmd;
		logic [7:0] len;
		logic [7:0] cnt;
		logic [7:0] pay;
		logic [7:0] acc;
		logic       pend;
		phase_t     ph;
		logic       txw;
		logic       ind;
		logic [7:0] chan;
		logic [7:0] addr;
		logic [7:0] sub;
		logic [7:0] pwr;
		logic       lp;
		logic       boot;
		logic [7:0] rssi;
		logic       st;
		txreq_t     tx;
	} main_st_t;

	typedef struct packed {
		logic       busy;
		logic       valid;
		logic [2:0] idx;
		logic [7:0] data;
		logic       done;
		txreq_t     req;
	} ftx_st_t;

endpackage : cmd_pkg

// ---- rtl/tx_if.sv ----
// request path from the interpreter to the frame sender
// assumes both ends share one clock
interface tx_if;
	logic            start;
	cmd_pkg::txreq_t req;
	logic            busy;
	logic            done;

	modport src (output start, output req, input busy, input done);
	modport snk (input start, input req, output busy, output done);
endinterface : tx_if

// ---- rtl/frame_tx.sv ----
// frame sender: start byte, command, length, payload, check byte
// assumes a byte sink taking a byte on valid and ready both high
`include "cmd_consts.svh"

module frame_tx (
	input  wire logic  sys_clk_i,
	input  wire logic  sys_rst_i,
	input  wire logic  ce_i,
	tx_if.snk          t,
	input  wire logic  tx_ready_i,
	output logic       tx_valid_o,
	output logic [7:0] tx_byte_o
);
	cmd_pkg::ftx_st_t q;
	cmd_pkg::ftx_st_t d;

	// ----------------------------------------
	// byte helpers
	// ----------------------------------------
	function automatic logic [7:0] chk(input cmd_pkg::txreq_t r);
		logic [7:0] a;
		a = `SOF ^ r.cmd ^ {5'h00, r.len};
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < r.len) a = a ^ r.pay[i];
		end
		return a;
	endfunction : chk

	function automatic logic [7:0] byte_at(input cmd_pkg::txreq_t r, input logic [2:0] ix);
		logic [2:0] k;
		k = ix - 3'h3;
		case (ix)
			3'h0: byte_at = `SOF;
			3'h1: byte_at = r.cmd;
			3'h2: byte_at = {5'h00, r.len};
			default: byte_at = (k < r.len) ? r.pay[k[1:0]] : chk(r);
		endcase
	endfunction : byte_at

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (t.start && !q.busy) begin
			d.busy  = 1'b1;
			d.valid = 1'b1;
			d.req   = t.req;
			d.idx   = 3'h0;
			d.data  = `SOF;
		end else if (q.valid && tx_ready_i) begin
			if (q.idx == 3'(q.req.len + 3'h3)) begin
				d.valid = 1'b0;
				d.busy  = 1'b0;
				d.done  = 1'b1;
			end else begin
				d.idx  = q.idx + 3'h1;
				d.data = byte_at(q.req, q.idx + 3'h1);
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) q <= '0;
		else if (ce_i) q <= d;
	end

	assign t.busy     = q.busy;
	assign t.done     = q.done;
	assign tx_valid_o = q.valid;
	assign tx_byte_o  = q.data;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_frame_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		ce_i && t.start && !q.busy |=> q.valid && q.data == `SOF && q.idx == 3'h0)
		else $error("frame does not open with the start byte");
	a_check_byte: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		q.valid && q.idx == 3'(q.req.len + 3'h3) |-> q.data == chk(q.req))
		else $error("check byte is not the xor of the frame");
endmodule : frame_tx

// ---- rtl/cmd_interp.sv ----
// command interpreter: parses request frames, answers, keeps volatile settings
// assumes byte streams in and out synchronous to sys_clk_i, 10 MHz
//
// How it works
// - frames are start 0x02, command, length, payload, check byte
// - check byte is xor of all earlier frame bytes from start
// - version query answers major, minor, revision
// - identity query answers product identifier then serial, MSB first
// - soft reset answers first, resets only after answer is sent
// - soft reset restores all volatile settings to defaults
// - state indication sent after soft reset and after power-up
// - state indication on entering or leaving low-power mode
// - signal-strength query answers stored last-packet strength
// - strength byte means dBm = -120 + 8 * value
// - strength reads zero until a packet arrives
// - loader request answers, then enters the firmware loader
// - only the hardware reset leaves the loader
// - operating-mode request 0x01 enters low power, answers status 0x01
// - channel request sets channel 0x00 to 0x13, answers status
// - source address request sets 0x00 to 0xFE, answers status
// - subnet request sets subnet, answers status
// - power request sets level 0x00 to 0x0A, answers status
`include "cmd_consts.svh"

module cmd_interp (
	input  wire logic  sys_clk_i,
	input  wire logic  sys_rst_i,
	input  wire logic  ce_i,
	input  wire logic  rx_valid_i,
	input  wire logic  [7:0] rx_byte_i,
	input  wire logic  tx_ready_i,
	output logic       tx_valid_o,
	output logic [7:0] tx_byte_o,
	input  wire logic  rssi_valid_i,
	input  wire logic  [7:0] rssi_i,
	input  wire logic  wake_i,
	output logic [7:0] channel_o,
	output logic [7:0] src_addr_o,
	output logic [7:0] subnet_o,
	output logic [7:0] power_o,
	output logic       low_power_mode_o,
	output logic       loader_o
);
	localparam logic [23:0] SERIAL = `SERIAL_NO;

	cmd_pkg::main_st_t q;
	cmd_pkg::main_st_t d;
	tx_if              t ();
	logic              free;
	logic              go;
	logic              rx_en;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic cmd_pkg::txreq_t mk(input logic [7:0] c, input logic [2:0] l,
		input logic [31:0] p);
		mk.cmd = c;
		mk.len = l;
		mk.pay = p;
	endfunction : mk

	function automatic logic [31:0] status(input logic bad);
		return {24'h00_0000, bad ? `ST_ERR : `ST_OK};
	endfunction : status

	function automatic logic subnet_bad(input logic [7:0] s);
		case (s)
			8'h00, 8'h30, 8'h33, 8'h63, 8'h66, 8'h92, 8'h99, 8'hCC: subnet_bad = 1'b1;
			default: subnet_bad = 1'b0;
		endcase
	endfunction : subnet_bad

	// ----------------------------------------
	// frame sender
	// ----------------------------------------
	frame_tx u_tx (
		.sys_clk_i  (sys_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.t          (t.snk),
		.tx_ready_i (tx_ready_i),
		.tx_valid_o (tx_valid_o),
		.tx_byte_o  (tx_byte_o)
	);

	assign t.start = q.st;
	assign t.req   = q.tx;

	assign free  = !q.txw && !t.busy && !q.st;
	assign go    = ce_i && free && q.pend && q.ph == cmd_pkg::PH_RUN;
	assign rx_en = ce_i && rx_valid_i && q.ph == cmd_pkg::PH_RUN && !q.lp;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic            send;
		logic            bad;
		logic [7:0]      rc;
		cmd_pkg::txreq_t r;
		send = 1'b0;
		bad  = 1'b0;
		rc   = q.cmd | `REPLY_BIT;
		r    = q.tx;
		d    = q;
		d.st = 1'b0;
		if (t.done) d.txw = 1'b0;

		// stored strength of the last packet, zero from start-up
		if (rssi_valid_i) d.rssi = rssi_i;

		// cleared before the parser, so a frame ending now stays pending
		if (go) d.pend = 1'b0;

		// receive parser
		if (rx_en) begin
			case (q.rs)
				cmd_pkg::R_IDLE: begin
					if (rx_byte_i == `SOF) begin
						d.rs  = cmd_pkg::R_CMD;
						d.acc = `SOF;
					end
				end
				cmd_pkg::R_CMD: begin
					d.cmd = rx_byte_i;
					d.acc = q.acc ^ rx_byte_i;
					d.rs  = cmd_pkg::R_LEN;
				end
				cmd_pkg::R_LEN: begin
					d.len = rx_byte_i;
					d.cnt = 8'h00;
					d.acc = q.acc ^ rx_byte_i;
					d.rs  = (rx_byte_i == `LEN_NONE) ? cmd_pkg::R_CS : cmd_pkg::R_PAY;
				end
				cmd_pkg::R_PAY: begin
					if (q.cnt == 8'h00) d.pay = rx_byte_i;
					d.acc = q.acc ^ rx_byte_i;
					d.cnt = q.cnt + 8'h01;
					if (q.cnt + 8'h01 == q.len) d.rs = cmd_pkg::R_CS;
				end
				cmd_pkg::R_CS: begin
					d.rs = cmd_pkg::R_IDLE;
					if (rx_byte_i == q.acc) d.pend = 1'b1;
				end
				default: d.rs = cmd_pkg::R_IDLE;
			endcase
		end

		// request execution
		if (go) begin
			case (q.cmd)
				`Q_VERSION: begin
					if (q.len == `LEN_NONE) begin
						send = 1'b1;
						r = mk(rc, `LEN_VERSION, {8'h00, `VER_REV, `VER_MINOR, `VER_MAJOR});
					end
				end
				`Q_IDENT: begin
					if (q.len == `LEN_NONE) begin
						send = 1'b1;
						r = mk(rc, `LEN_IDENT,
							{SERIAL[7:0], SERIAL[15:8], SERIAL[23:16], `PRODUCT_ID});
					end
				end
				`Q_SRST: begin
					if (q.len == `LEN_NONE) begin
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(1'b0));
						d.ph = cmd_pkg::PH_SRST;
					end
				end
				`Q_RSSI: begin
					if (q.len == `LEN_NONE) begin
						send = 1'b1;
						r = mk(rc, `LEN_STATUS, {24'h00_0000, q.rssi});
					end
				end
				`Q_LOADER: begin
					if (q.len == `LEN_NONE) begin
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(1'b0));
						d.ph = cmd_pkg::PH_LOAD;
					end
				end
				`Q_OPMODE: begin
					if (q.len == `LEN_ONE && q.pay == `MODE_LP) begin
						send  = 1'b1;
						d.lp  = 1'b1;
						d.ind = 1'b1;
						r     = mk(rc, `LEN_STATUS, {24'h00_0000, `MODE_LP});
					end
				end
				`Q_CHAN: begin
					if (q.len == `LEN_ONE) begin
						bad  = q.pay > `CHAN_MAX;
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(bad));
						if (!bad) d.chan = q.pay;
					end
				end
				`Q_ADDR: begin
					if (q.len == `LEN_ONE) begin
						bad  = q.pay > `ADDR_MAX;
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(bad));
						if (!bad) d.addr = q.pay;
					end
				end
				`Q_SUBNET: begin
					if (q.len == `LEN_ONE) begin
						bad  = subnet_bad(q.pay);
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(bad));
						if (!bad) d.sub = q.pay;
					end
				end
				`Q_POWER: begin
					if (q.len == `LEN_ONE) begin
						bad  = q.pay > `POWER_MAX;
						send = 1'b1;
						r    = mk(rc, `LEN_STATUS, status(bad));
						if (!bad) d.pwr = q.pay;
					end
				end
				default: send = 1'b0;
			endcase
		end else if (ce_i && free && q.ind && q.ph == cmd_pkg::PH_RUN) begin
			// owed indication, after any answer
			send  = 1'b1;
			d.ind = 1'b0;
			r     = mk(`IND_STATE, `LEN_STATUS, {24'h00_0000, 7'h00, q.lp});
		end

		// wake from low power, after the send so a new owed indication wins
		if (ce_i && wake_i && q.lp && q.ph == cmd_pkg::PH_RUN) begin
			d.lp  = 1'b0;
			d.ind = 1'b1;
		end

		if (send) begin
			d.st  = 1'b1;
			d.txw = 1'b1;
			d.tx  = r;
		end

		// after the answer has gone out
		if (ce_i && t.done) begin
			case (q.ph)
				cmd_pkg::PH_SRST: begin
					d.ph   = cmd_pkg::PH_RUN;
					d.chan = `DEF_CHAN;
					d.addr = `DEF_ADDR;
					d.sub  = `DEF_SUBNET;
					d.pwr  = `DEF_POWER;
					d.lp   = 1'b0;
					d.rssi = `RSSI_NONE;
					d.rs   = cmd_pkg::R_IDLE;
					d.pend = 1'b0;
					d.ind  = 1'b1;
				end
				cmd_pkg::PH_LOAD: begin
					d.ph   = cmd_pkg::PH_BOOT;
					d.boot = 1'b1;
					d.pend = 1'b0;
					d.ind  = 1'b0;
				end
				default: d.ph = q.ph;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q      <= '0;
			q.chan <= `DEF_CHAN;
			q.addr <= `DEF_ADDR;
			q.sub  <= `DEF_SUBNET;
			q.pwr  <= `DEF_POWER;
			q.rssi <= `RSSI_NONE;
			q.ind  <= 1'b1;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign channel_o        = q.chan;
	assign src_addr_o       = q.addr;
	assign subnet_o         = q.sub;
	assign power_o          = q.pwr;
	assign low_power_mode_o = q.lp;
	assign loader_o         = q.boot;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_reply_code: assert property (
		q.st && q.tx.cmd != `IND_STATE |-> q.tx.cmd == (q.cmd | `REPLY_BIT))
		else $error("answer code is not request code with bit 6");

	a_version_body: assert property (
		go && q.cmd == `Q_VERSION && q.len == `LEN_NONE
		|=> q.st && q.tx.len == `LEN_VERSION && q.tx.pay[0] == `VER_MAJOR
			&& q.tx.pay[2] == `VER_REV)
		else $error("version answer malformed");

	a_ident_body: assert property (
		go && q.cmd == `Q_IDENT && q.len == `LEN_NONE
		|=> q.tx.len == `LEN_IDENT && q.tx.pay[0] == `PRODUCT_ID
			&& q.tx.pay[1] == SERIAL[23:16])
		else $error("identity answer malformed");

	a_srst_wait: assert property (
		q.ph == cmd_pkg::PH_SRST && !(ce_i && t.done) |=> q.ph == cmd_pkg::PH_SRST)
		else $error("soft reset taken before the answer was sent");

	a_srst_defaults: assert property (
		ce_i && q.ph == cmd_pkg::PH_SRST && t.done
		|=> q.chan == `DEF_CHAN && q.addr == `DEF_ADDR && q.sub == `DEF_SUBNET
			&& q.pwr == `DEF_POWER)
		else $error("settings not restored by soft reset");

	a_restart_ind: assert property (
		ce_i && q.ph == cmd_pkg::PH_SRST && t.done |=> q.ind && !q.lp ##[1:3] q.st)
		else $error("no state indication after restart");

	a_wake_ind: assert property (
		ce_i && wake_i && q.lp && q.ph == cmd_pkg::PH_RUN |=> !q.lp && q.ind)
		else $error("leaving low power owes no indication");

	a_rssi_stored: assert property (
		go && q.cmd == `Q_RSSI && q.len == `LEN_NONE
		|=> q.st && q.tx.pay[0] == $past(q.rssi))
		else $error("strength answer is not the stored value");

	a_loader_hold: assert property (
		q.boot |=> q.boot && !q.st && !q.pend)
		else $error("loader left without hardware reset");

	a_lp_enter: assert property (
		go && q.cmd == `Q_OPMODE && q.len == `LEN_ONE && q.pay == `MODE_LP
		|=> q.lp && q.ind && q.tx.cmd == 8'h68 && q.tx.pay[0] == `MODE_LP)
		else $error("low power entry wrong");

	a_bad_keep: assert property (
		go && q.cmd == `Q_CHAN && q.len == `LEN_ONE && q.pay > `CHAN_MAX
		|=> $stable(q.chan) && q.tx.pay[0] == `ST_ERR)
		else $error("out of range channel accepted");

	a_bad_sum: assert property (
		rx_en && q.rs == cmd_pkg::R_CS && rx_byte_i != q.acc && !q.pend |=> !q.pend)
		else $error("frame with bad check byte accepted");

	c_soft_reset: cover property (ce_i && q.ph == cmd_pkg::PH_SRST && t.done);
	c_loader: cover property (q.ph == cmd_pkg::PH_LOAD ##[1:200] q.boot);
	c_lp_cycle: cover property (q.lp ##[1:200] !q.lp);
	c_bad_sum: cover property (rx_en && q.rs == cmd_pkg::R_CS && rx_byte_i != q.acc);
endmodule : cmd_interp

// ---- testbench/host_model.sv ----
// host model: sends request frames, collects answer and indication frames
// assumes byte links sampled on the rising edge of sys_clk_i
module host_model (
	input  wire logic       sys_clk_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_byte_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_byte_i,
	output logic            tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		logic [7:0]  cmd;
		logic [7:0]  len;
		logic [31:0] pay;
		logic        ok;
	} frame_t;

	frame_t     frames[$];
	frame_t     cur;
	logic [7:0] acc;
	int         idx;
	logic       slow;

	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o  = 8'h00;
		tx_ready_o = 1'b1;
		slow       = 1'b0;
		idx        = 0;
		acc        = 8'h00;
	end

	// ----------------------------------------
	// request sender, one request outstanding
	// ----------------------------------------
	task automatic put_byte(input logic [7:0] b);
		@(posedge sys_clk_i);
		#1;
		rx_valid_o = 1'b1;
		rx_byte_o  = b;
	endtask : put_byte

	// caller waits for the answer before the next send
	task automatic send(input logic [7:0] c, input logic [7:0] l, input logic [7:0] p,
			input logic corrupt);
		logic [7:0] cs;
		cs = 8'h02 ^ c ^ l;
		put_byte(8'h02);
		put_byte(c);
		put_byte(l);
		if (l != 8'h00) begin
			put_byte(p);
			cs = cs ^ p;
		end
		put_byte(corrupt ? ~cs : cs);
		@(posedge sys_clk_i);
		#1;
		rx_valid_o = 1'b0;
		rx_byte_o  = ~rx_byte_o;
	endtask : send

	// ----------------------------------------
	// frame collector, indications kept in order
	// ----------------------------------------
	always @(posedge sys_clk_i) begin
		if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
			if (idx == 0) begin
				acc     = 8'h00;
				cur.pay = 32'h0000_0000;
				cur.ok  = (tx_byte_i === 8'h02);
			end
			if (idx == 1) cur.cmd = tx_byte_i;
			if (idx == 2) cur.len = tx_byte_i;
			if (idx > 2 && idx < cur.len + 3) cur.pay = {cur.pay[23:0], tx_byte_i};
			acc = acc ^ tx_byte_i;
			idx = idx + 1;
			if (idx > 3 && idx == cur.len + 4) begin
				cur.ok = cur.ok && (acc === 8'h00);
				frames.push_back(cur);
				idx = 0;
			end
		end
		#1;
		tx_ready_o = slow ? ~tx_ready_o : 1'b1;
	end

	task automatic take(output logic [7:0] c, output logic [7:0] l, output logic [31:0] p,
			output logic ok, output logic got);
		frame_t f;
		got = 1'b0;
		for (int i = 0; i < 400 && !got; i++) begin
			if (frames.size() > 0) begin
				f   = frames.pop_front();
				c   = f.cmd;
				l   = f.len;
				p   = f.pay;
				ok  = f.ok;
				got = 1'b1;
			end else begin
				@(posedge sys_clk_i);
			end
		end
	endtask : take

endmodule : host_model

// ---- testbench/tb.sv ----
// testbench: runs the command interpreter through request scenarios
// assumes cmd_interp and host_model compiled before it
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk, rst, ce, rx_valid, tx_ready, tx_valid, rssi_valid, wake, lp, loader;
	logic [7:0] rx_byte, tx_byte, rssi, channel, src_addr, subnet, power;
	int         n_mismatch, n_checks;

	cmd_interp DUT (.sys_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .rx_valid_i(rx_valid),
		.rx_byte_i(rx_byte), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
		.rssi_valid_i(rssi_valid), .rssi_i(rssi), .wake_i(wake), .channel_o(channel),
		.src_addr_o(src_addr), .subnet_o(subnet), .power_o(power), .low_power_mode_o(lp),
		.loader_o(loader));

	host_model host (.sys_clk_i(clk), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
		.tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_ready_o(tx_ready));

	always #50 clk = ~clk;

	// ----------------------------------------
	// shared checks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic expect_frame(input logic [7:0] c, input logic [7:0] l, input logic [31:0] p);
		logic [7:0]  gc;
		logic [7:0]  gl;
		logic [31:0] gp;
		logic        ok;
		logic        got;
		host.take(gc, gl, gp, ok, got);
		chk({31'h0, got}, 32'h0000_0001, "frame arrived");
		chk({gc, gl, 15'h0, ok}, {c, l, 15'h0, 1'b1}, "frame head");
		chk(gp, p, "frame payload");
	endtask : expect_frame

	task automatic expect_none();
		repeat (60) @(posedge clk);
		chk(host.frames.size(), 32'h0000_0000, "no frame");
	endtask : expect_none

	task automatic chk_defaults();
		chk({channel, src_addr, subnet, power}, 32'h0600_0105, "settings");
	endtask : chk_defaults

	task automatic do_reset();
		rst = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
	endtask : do_reset

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1;
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask : pulse

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_powerup();
		chk_defaults();
		chk({30'h0, lp, loader}, 32'h0000_0000, "mode flags");
		expect_frame(8'hC0, 8'h01, 32'h0000_0000);
		$display("test powerup done");
	endtask : t_powerup

	task automatic t_queries();
		host.send(8'h0C, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h4C, 8'h03, 32'h0001_0000);
		host.send(8'h0B, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h4B, 8'h04, 32'h5A00_0001);
		host.send(8'h0D, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h4D, 8'h01, 32'h0000_0000);
		rssi = 8'h0B;
		pulse(rssi_valid);
		rssi = 8'h20;
		host.send(8'h0D, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h4D, 8'h01, 32'h0000_000B);
		$display("test queries done");
	endtask : t_queries

	task automatic t_settings();
		// host keeps to legal address and subnet values
		logic [7:0] tc[6] = '{8'h20, 8'h20, 8'h21, 8'h22, 8'h23, 8'h23};
		logic [7:0] tv[6] = '{8'h13, 8'h14, 8'hFE, 8'h55, 8'h0A, 8'h0B};
		logic [7:0] ts[6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
		logic [7:0] te[6] = '{8'h13, 8'h13, 8'hFE, 8'h55, 8'h0A, 8'h0A};
		logic [7:0] now;
		host.slow = 1'b1;
		for (int i = 0; i < 6; i++) begin
			host.send(tc[i], 8'h01, tv[i], 1'b0);
			expect_frame(tc[i] | 8'h40, 8'h01, {24'h0, ts[i]});
			case (tc[i])
				8'h20: now = channel;
				8'h21: now = src_addr;
				8'h22: now = subnet;
				default: now = power;
			endcase
			chk({24'h0, now}, {24'h0, te[i]}, "setting");
		end
		host.slow = 1'b0;
		host.send(8'h20, 8'h01, 8'h02, 1'b1);
		expect_none();
		chk({24'h0, channel}, 32'h0000_0013, "channel kept");
		$display("test settings done");
	endtask : t_settings

	task automatic t_softreset();
		host.send(8'h05, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h45, 8'h01, 32'h0000_0000);
		expect_frame(8'hC0, 8'h01, 32'h0000_0000);
		chk_defaults();
		host.send(8'h0D, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h4D, 8'h01, 32'h0000_0000);
		$display("test softreset done");
	endtask : t_softreset

	task automatic t_lowpower();
		host.send(8'h28, 8'h01, 8'h01, 1'b0);
		expect_frame(8'h68, 8'h01, 32'h0000_0001);
		expect_frame(8'hC0, 8'h01, 32'h0000_0001);
		chk({31'h0, lp}, 32'h0000_0001, "low power");
		host.send(8'h0C, 8'h00, 8'h00, 1'b0);
		expect_none();
		pulse(wake);
		expect_frame(8'hC0, 8'h01, 32'h0000_0000);
		chk({31'h0, lp}, 32'h0000_0000, "run mode");
		$display("test lowpower done");
	endtask : t_lowpower

	task automatic t_loader();
		host.send(8'h12, 8'h00, 8'h00, 1'b0);
		expect_frame(8'h52, 8'h01, 32'h0000_0000);
		repeat (3) @(posedge clk);
		#1;
		chk({31'h0, loader}, 32'h0000_0001, "loader entered");
		host.send(8'h0C, 8'h00, 8'h00, 1'b0);
		pulse(wake);
		expect_none();
		chk({31'h0, loader}, 32'h0000_0001, "loader kept");
		do_reset();
		chk({31'h0, loader}, 32'h0000_0000, "loader left");
		expect_frame(8'hC0, 8'h01, 32'h0000_0000);
		$display("test loader done");
	endtask : t_loader

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk        = 1'b0;
		rst        = 1'b1;
		ce         = 1'b1;
		rssi_valid = 1'b0;
		rssi       = 8'h00;
		wake       = 1'b0;
		n_mismatch = 0;
		n_checks   = 0;
		do_reset();
		t_powerup();
		t_queries();
		t_settings();
		t_softreset();
		t_lowpower();
		t_loader();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end

endmodule : tb
